// ==== rtl/arb_pkg.sv ====
package arb_pkg;
    // bus size
    localparam int NUM_MASTERS = 6;
    localparam int NUM_DMA = 8;
    localparam int IDX_W = 3;
    // read-only port addresses
    localparam logic [15:0] OFS_BUS_OWNER = 16'h040c;
    localparam logic [15:0] OFS_LAST_MASTER = 16'h0464;
    // bus owner status fields
    localparam int OWNER_MASTER_BIT = 0;
    localparam int OWNER_CPU_BIT = 1;
    localparam logic [7:0] REG_RST = 8'h00;
    // timeout counters
    localparam int PREEMPT_W = 6;
    localparam int CMD_W = 8;
    localparam logic [PREEMPT_W-1:0] PREEMPT_LIMIT = 6'h3f;
    localparam logic [CMD_W-1:0] CMD_LIMIT = 8'hff;
    // pin bundle layout for the input synchroniser
    localparam int PIN_W = 18;
    localparam int PIN_DREQ = 0;
    localparam int PIN_MREQ = 8;
    localparam int PIN_REF = 14;
    localparam int PIN_ACK = 15;
    localparam int PIN_CMD = 16;
    localparam int PIN_IORD = 17;
    // strobes are active low, so they idle high
    localparam logic [PIN_W-1:0] PIN_RST = 18'h30000;
    // arbiter states
    typedef enum logic [3:0] {
        ST_CPU = 4'h1,
        ST_YIELD = 4'h2,
        ST_ARB = 4'h4,
        ST_OTHER = 4'h8
    } arb_state_t;
    // top level rotation slots
    typedef enum logic [1:0] {
        TURN_REF = 2'h0,
        TURN_DMA = 2'h1,
        TURN_GRP = 2'h2
    } turn_t;
endpackage

// ==== rtl/dma_prio.sv ====
`timescale 1ns/1ps
`default_nettype none
module dma_prio import arb_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic rotateLow,
    input wire logic rotateHigh,
    pick_if.picker pk
);
    // first request at or after top, {valid, index}
    function automatic logic [2:0] pick4(logic [3:0] r, logic [1:0] top);
        logic found;
        logic [1:0] j;
        logic [1:0] sel;
        found = 1'b0;
        sel = 2'h0;
        for (int i = 0; i < 4; i++) begin
            j = top + 2'(i);
            if (!found && r[j]) begin
                found = 1'b1;
                sel = j;
            end
        end
        return {found, sel};
    endfunction

    logic [1:0] lowTop_q, lowTop_d; // highest channel of group 0-3
    logic [1:0] highTop_q, highTop_d; // highest slot of cascade group
    logic [2:0] lo; // winner of channels 0-3
    logic [2:0] hi; // winner of slots cascade,5,6,7

    // low group feeds slot 0 of the high group
    assign lo = pick4(pk.req[3:0], lowTop_q);
    assign hi = pick4({pk.req[7:5], lo[2]}, highTop_q);
    assign pk.valid = hi[2];
    assign pk.idx = (hi[1:0] == 2'h0) ? {1'b0, lo[1:0]} : {1'b1, hi[1:0]};

    // fixed mode pins the pointers, rotating moves past the served one
    always_comb begin
        lowTop_d = 2'h0;
        highTop_d = 2'h0;
        if (rotateLow) begin
            lowTop_d = lowTop_q;
            if (pk.advance && hi[2] && hi[1:0] == 2'h0) begin
                lowTop_d = lo[1:0] + 2'h1;
            end
        end
        if (rotateHigh) begin
            highTop_d = highTop_q;
            if (pk.advance && hi[2]) begin
                highTop_d = hi[1:0] + 2'h1;
            end
        end
    end

    // pointer registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            lowTop_q <= 2'h0;
            highTop_q <= 2'h0;
        end else begin
            lowTop_q <= lowTop_d;
            highTop_q <= highTop_d;
        end
    end

    property p_dma_rotate;
        @(posedge clk) disable iff (sys_rst)
        rotateLow && pk.advance && pk.idx == 3'h1 |=> lowTop_q == 2'h2;
    endproperty
    a_dma_rotate: assert property (p_dma_rotate)
        else $error("dma low group did not rotate");

    property p_dma_cascade;
        @(posedge clk) disable iff (sys_rst)
        highTop_q == 2'h0 && (|pk.req[3:0]) |-> pk.valid && !pk.idx[2];
    endproperty
    a_dma_cascade: assert property (p_dma_cascade)
        else $error("dma low group lost its cascade slot");
endmodule
`default_nettype wire

// ==== rtl/eisa_system_arbiter.sv ====
// Behaviour
// - rotate refresh, dma and master group
// - skip parties not requesting on their turn
// - alternate cpu and eisa masters in group
// - six masters rotate, served one goes last
// - dma priority fixed or rotating by mode
// - dma channels ranked as four plus three
// - nmi pending bypasses masters and dma
// - two read-only ports show bus owners
// - refresh requests come from timer counter
// - preemption starts six-bit master timeout
// - command strobe starts eight-bit timeout
`timescale 1ns/1ps
`default_nettype none
module eisa_system_arbiter import arb_pkg::*; (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [NUM_DMA-1:0] dmaReq,
    input wire logic dmaRotateLow,
    input wire logic dmaRotateHigh,
    input wire logic [NUM_MASTERS-1:0] masterReq,
    input wire logic dramRefreshRequest,
    input wire logic refreshDone,
    input wire logic cpuHoldAck,
    input wire logic nmiPending,
    input wire logic cmdStrobeN,
    input wire logic ioReadN,
    input wire logic [15:0] ioAddr,
    output logic cpuHoldReq,
    output logic cpuOwnsBus,
    output logic refreshGrant,
    output logic dmaGrant,
    output logic [IDX_W-1:0] dmaChannel,
    output logic [NUM_MASTERS-1:0] masterGrant,
    output logic masterTimeout,
    output logic cmdTimeout,
    output logic [7:0] ioData,
    output logic ioDataOe
);
    // index to one-hot master grant
    function automatic logic [NUM_MASTERS-1:0] oneHot(logic [2:0] i);
        return NUM_MASTERS'(1) << i;
    endfunction

    // input synchroniser, three stages plus agreement filter
    logic [PIN_W-1:0] s1_q, s2_q, s3_q; // raw pin stages
    logic [PIN_W-1:0] pin_q, pin_d; // filtered pin levels
    logic [PIN_W-1:0] agree; // stages two and three equal
    always_comb begin
        agree = ~(s2_q ^ s3_q);
        pin_d = (agree & s3_q) | (~agree & pin_q);
    end
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            s1_q <= PIN_RST;
            s2_q <= PIN_RST;
            s3_q <= PIN_RST;
            pin_q <= PIN_RST;
        end else begin
            s1_q <= {ioReadN, cmdStrobeN, cpuHoldAck, dramRefreshRequest,
                     masterReq, dmaReq};
            s2_q <= s1_q;
            s3_q <= s2_q;
            pin_q <= pin_d;
        end
    end

    // filtered views of the pins
    logic [NUM_DMA-1:0] dreq; // dma requests
    logic [NUM_MASTERS-1:0] mreq; // master requests
    logic refLvl; // refresh timer output
    logic ack; // cpu released the bus
    logic cmdAct; // command strobe asserted
    logic rdAct; // io read strobe asserted
    assign dreq = pin_q[PIN_DREQ +: NUM_DMA];
    assign mreq = pin_q[PIN_MREQ +: NUM_MASTERS];
    assign refLvl = pin_q[PIN_REF];
    assign ack = pin_q[PIN_ACK];
    assign cmdAct = !pin_q[PIN_CMD];
    assign rdAct = !pin_q[PIN_IORD];

    // sub arbiters for dma channels and eisa masters
    pick_if #(.N(NUM_DMA)) dmaPick();
    pick_if #(.N(NUM_MASTERS)) mstPick();
    logic dmaAdv; // dma winner granted this cycle
    logic mstAdv; // master winner granted this cycle
    assign dmaPick.req = dreq;
    assign dmaPick.advance = dmaAdv;
    assign mstPick.req = mreq;
    assign mstPick.advance = mstAdv;

    dma_prio u_dma (
        .clk(clk),
        .sys_rst(sys_rst),
        .rotateLow(dmaRotateLow),
        .rotateHigh(dmaRotateHigh),
        .pk(dmaPick.picker)
    );

    master_rr #(.N(NUM_MASTERS)) u_mst (
        .clk(clk),
        .sys_rst(sys_rst),
        .pk(mstPick.picker)
    );

    // arbiter state
    arb_state_t state_q, state_d; // bus phase
    turn_t turn_q, turn_d; // next top level slot
    turn_t owner_q, owner_d; // non-cpu owner kind
    turn_t win; // top level winner in arbitration
    logic grpMaster_q, grpMaster_d; // masters next in the group
    logic refPend_q, refPend_d; // refresh waiting for the bus
    logic refPrev_q; // refresh level last cycle
    logic refRise; // new refresh request
    logic [2:0] dmaCh_q, dmaCh_d; // granted dma channel
    logic [2:0] mst_q, mst_d; // granted master
    logic [2:0] lastMst_q, lastMst_d; // master granted most recently
    logic [PREEMPT_W-1:0] preCnt_q, preCnt_d; // preemption timeout
    logic [CMD_W-1:0] cmdCnt_q, cmdCnt_d; // command timeout
    logic dmaOk; // dma may compete
    logic mstOk; // masters may compete
    logic otherWants; // someone besides the cpu needs the bus
    logic preempt; // owning master is asked to leave
    logic mTo_d; // master timeout pulse
    logic cTo_d; // command timeout pulse
    logic holdReq_d, cpuOwn_d, refG_d, dmaG_d; // output next values
    logic [NUM_MASTERS-1:0] mstG_d; // master grant next value
    logic [7:0] ioData_d; // read data next value
    logic ioOe_d; // read drive next value

    // timer counter output rising edge is a refresh request
    assign refRise = refLvl && !refPrev_q;
    // nmi keeps masters and dma out of the rotation
    assign dmaOk = dmaPick.valid && !nmiPending;
    assign mstOk = mstPick.valid && !nmiPending;
    assign otherWants = refPend_q || dmaOk || mstOk;
    // three-way pick from the turn, idle slots skipped
    always_comb begin
        win = turn_q;
        if (win == TURN_REF && !refPend_q) begin
            win = TURN_DMA;
        end
        if (win == TURN_DMA && !dmaOk) begin
            win = TURN_GRP;
        end
    end
    assign preempt = (owner_q == TURN_GRP) && (refPend_q || dmaOk ||
                     nmiPending || |(mreq & ~oneHot(mst_q)));

    // next state of the arbiter
    always_comb begin
        state_d = state_q;
        turn_d = turn_q;
        owner_d = owner_q;
        grpMaster_d = grpMaster_q;
        refPend_d = refPend_q || refRise; // set wins over clear
        dmaAdv = 1'b0;
        mstAdv = 1'b0;
        dmaCh_d = dmaCh_q;
        mst_d = mst_q;
        lastMst_d = lastMst_q;
        preCnt_d = '0;
        mTo_d = 1'b0;
        unique case (state_q)
            ST_CPU: begin
                // cpu parks on the bus until someone else asks
                if (otherWants) begin
                    state_d = ST_YIELD;
                end
            end
            ST_YIELD: begin
                // wait for cpu release before any grant
                if (ack) begin
                    state_d = ST_ARB;
                end
            end
            ST_ARB: begin
                // bus free, no grant out this cycle
                turn_d = (win == TURN_GRP) ? TURN_REF :
                         (win == TURN_REF) ? TURN_DMA : TURN_GRP;
                state_d = ST_OTHER;
                owner_d = win;
                if (win == TURN_REF) begin
                    refPend_d = refRise;
                end else if (win == TURN_DMA) begin
                    dmaCh_d = dmaPick.idx;
                    dmaAdv = 1'b1;
                end else if (grpMaster_q && mstOk) begin
                    // master turn after a cpu tenure
                    mst_d = mstPick.idx;
                    lastMst_d = mstPick.idx;
                    mstAdv = 1'b1;
                    grpMaster_d = 1'b0;
                end else begin
                    // cpu served, masters go next
                    state_d = ST_CPU;
                    grpMaster_d = 1'b1;
                end
            end
            ST_OTHER: begin
                // owner release returns to arbitration
                if (owner_q == TURN_REF) begin
                    if (refreshDone) begin
                        state_d = ST_ARB;
                    end
                end else if (owner_q == TURN_DMA) begin
                    if (!dreq[dmaCh_q]) begin
                        state_d = ST_ARB;
                    end
                end else if (!mreq[mst_q]) begin
                    state_d = ST_ARB;
                end else if (preempt) begin
                    // bounded stay once preempted
                    preCnt_d = preCnt_q + 6'h01;
                    if (preCnt_q == PREEMPT_LIMIT) begin
                        preCnt_d = '0;
                        mTo_d = 1'b1;
                        state_d = ST_ARB;
                    end
                end
            end
        endcase
    end

    // outputs follow the next state, at most one grant
    always_comb begin
        cpuOwn_d = (state_d == ST_CPU) || (state_d == ST_YIELD);
        holdReq_d = !(state_d == ST_CPU);
        refG_d = (state_d == ST_OTHER) && (owner_d == TURN_REF);
        dmaG_d = (state_d == ST_OTHER) && (owner_d == TURN_DMA);
        mstG_d = '0;
        if (state_d == ST_OTHER && owner_d == TURN_GRP) begin
            mstG_d = oneHot(mst_d);
        end
    end

    // command strobe watchdog
    always_comb begin
        cmdCnt_d = '0;
        cTo_d = 1'b0;
        if (cmdAct) begin
            cmdCnt_d = (cmdCnt_q == CMD_LIMIT) ? cmdCnt_q : cmdCnt_q + 8'h01;
            cTo_d = (cmdCnt_q == CMD_LIMIT - 8'h01);
        end
    end

    // read-only status ports, writes ignored
    always_comb begin
        ioOe_d = 1'b0;
        ioData_d = REG_RST;
        if (rdAct && ioAddr == OFS_BUS_OWNER) begin
            ioOe_d = 1'b1;
            ioData_d[OWNER_MASTER_BIT] = |masterGrant;
            ioData_d[OWNER_CPU_BIT] = cpuOwnsBus;
        end else if (rdAct && ioAddr == OFS_LAST_MASTER) begin
            ioOe_d = 1'b1;
            ioData_d[2:0] = lastMst_q;
        end
    end

    // registers, reset parks the bus on the cpu
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_CPU;
            turn_q <= TURN_REF;
            owner_q <= TURN_REF;
            grpMaster_q <= 1'b1;
            refPend_q <= 1'b0;
            refPrev_q <= 1'b0;
            dmaCh_q <= 3'h0;
            mst_q <= 3'h0;
            lastMst_q <= 3'h0;
            preCnt_q <= '0;
            cmdCnt_q <= '0;
            cpuHoldReq <= 1'b0;
            cpuOwnsBus <= 1'b1;
            refreshGrant <= 1'b0;
            dmaGrant <= 1'b0;
            dmaChannel <= 3'h0;
            masterGrant <= '0;
            masterTimeout <= 1'b0;
            cmdTimeout <= 1'b0;
            ioData <= REG_RST;
            ioDataOe <= 1'b0;
        end else begin
            state_q <= state_d;
            turn_q <= turn_d;
            owner_q <= owner_d;
            grpMaster_q <= grpMaster_d;
            refPend_q <= refPend_d;
            refPrev_q <= refLvl;
            dmaCh_q <= dmaCh_d;
            mst_q <= mst_d;
            lastMst_q <= lastMst_d;
            preCnt_q <= preCnt_d;
            cmdCnt_q <= cmdCnt_d;
            cpuHoldReq <= holdReq_d;
            cpuOwnsBus <= cpuOwn_d;
            refreshGrant <= refG_d;
            dmaGrant <= dmaG_d;
            dmaChannel <= dmaCh_d;
            masterGrant <= mstG_d;
            masterTimeout <= mTo_d;
            cmdTimeout <= cTo_d;
            ioData <= ioData_d;
            ioDataOe <= ioOe_d;
        end
    end

    logic anyGrant; // some owner other than the cpu
    assign anyGrant = refreshGrant || dmaGrant || (|masterGrant);

    property p_one_grant;
        @(posedge clk) disable iff (sys_rst)
        $onehot0({cpuOwnsBus, refreshGrant, dmaGrant, masterGrant});
    endproperty
    a_one_grant: assert property (p_one_grant)
        else $error("more than one bus grant");

    property p_gap;
        @(posedge clk) disable iff (sys_rst)
        $rose(anyGrant) |-> $past(!anyGrant && !cpuOwnsBus);
    endproperty
    a_gap: assert property (p_gap)
        else $error("grant given without a free cycle");

    property p_reset;
        @(posedge clk) sys_rst |=> cpuOwnsBus && !anyGrant && turn_q == TURN_REF;
    endproperty
    a_reset: assert property (p_reset)
        else $error("reset did not park the bus on the cpu");

    property p_nmi;
        @(posedge clk) disable iff (sys_rst)
        nmiPending && state_q == ST_ARB |=> !dmaGrant && masterGrant == '0;
    endproperty
    a_nmi: assert property (p_nmi)
        else $error("nmi did not bypass masters and dma");

    property p_rotate;
        @(posedge clk) disable iff (sys_rst)
        state_q == ST_ARB && refPend_q && turn_q == TURN_REF
            |=> refreshGrant ##0 turn_q == TURN_DMA;
    endproperty
    a_rotate: assert property (p_rotate)
        else $error("refresh turn not served or rotation stuck");

    property p_skip;
        @(posedge clk) disable iff (sys_rst)
        state_q == ST_ARB && turn_q == TURN_REF && !refPend_q && dmaOk
            |=> dmaGrant;
    endproperty
    a_skip: assert property (p_skip)
        else $error("idle refresh slot not skipped");

    property p_alternate;
        @(posedge clk) disable iff (sys_rst)
        state_q == ST_ARB && win == TURN_GRP && grpMaster_q && mstOk
            |=> masterGrant != '0;
    endproperty
    a_alternate: assert property (p_alternate)
        else $error("master not served after cpu tenure");

    property p_refresh_req;
        @(posedge clk) disable iff (sys_rst)
        $rose(refLvl) |=> refPend_q;
    endproperty
    a_refresh_req: assert property (p_refresh_req)
        else $error("refresh request lost");

    property p_preempt;
        @(posedge clk) disable iff (sys_rst)
        state_q == ST_OTHER && preCnt_q == PREEMPT_LIMIT && preempt
            && mreq[mst_q] |=> masterTimeout && masterGrant == '0;
    endproperty
    a_preempt: assert property (p_preempt)
        else $error("preempted master kept the bus");

    property p_cmd;
        @(posedge clk) disable iff (sys_rst)
        cmdAct && cmdCnt_q == 8'hfe |=> cmdTimeout ##1 !cmdTimeout;
    endproperty
    a_cmd: assert property (p_cmd)
        else $error("command timeout missing or repeated");

    property p_port;
        @(posedge clk) disable iff (sys_rst)
        rdAct && ioAddr == OFS_LAST_MASTER |=> ioDataOe
            && ioData == {5'h00, $past(lastMst_q)};
    endproperty
    a_port: assert property (p_port)
        else $error("last master port wrong");

    c_master: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(|masterGrant));
    c_refresh: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(refreshGrant));
    c_dma: cover property (@(posedge clk) disable iff (sys_rst)
        $rose(dmaGrant));
    c_mto: cover property (@(posedge clk) disable iff (sys_rst)
        masterTimeout);
endmodule
`default_nettype wire

// ==== rtl/master_rr.sv ====
`timescale 1ns/1ps
`default_nettype none
module master_rr import arb_pkg::*; #(parameter int N = NUM_MASTERS) (
    input wire logic clk,
    input wire logic sys_rst,
    pick_if.picker pk
);
    logic [2:0] top_q, top_d; // master with highest priority
    logic found; // some master requests
    logic [2:0] sel; // winning master

    // search from top around the ring
    always_comb begin
        int j;
        j = 0;
        found = 1'b0;
        sel = 3'h0;
        for (int i = 0; i < N; i++) begin
            j = (int'(top_q) + i) % N;
            if (!found && pk.req[j]) begin
                found = 1'b1;
                sel = 3'(j);
            end
        end
    end
    assign pk.valid = found;
    assign pk.idx = sel;

    // served master drops to lowest priority
    always_comb begin
        top_d = top_q;
        if (pk.advance && found) begin
            top_d = (sel == 3'(N - 1)) ? 3'h0 : sel + 3'h1;
        end
    end

    // pointer register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            top_q <= 3'h0;
        end else begin
            top_q <= top_d;
        end
    end

    property p_mst_rotate;
        @(posedge clk) disable iff (sys_rst)
        pk.advance && pk.valid && pk.idx == 3'h2 |=> top_q == 3'h3;
    endproperty
    a_mst_rotate: assert property (p_mst_rotate)
        else $error("served master kept its priority");
endmodule
`default_nettype wire

// ==== rtl/pick_if.sv ====
`timescale 1ns/1ps
`default_nettype none
// request vector in, winner out, advance moves the rotation
interface pick_if #(parameter int N = 6);
    logic [N-1:0] req;
    logic advance;
    logic valid;
    logic [2:0] idx;
    modport arb (output req, output advance, input valid, input idx);
    modport picker (input req, input advance, output valid, output idx);
endinterface
`default_nettype wire

// ==== test/eisa_system_arbiter_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED %0t value mismatch", $time); end end
`define WAITC(c) begin n = 0; while (!(c) && n < 300) begin \
    @(negedge clk); n++; end if (!(c)) begin bad_count++; \
    $display("CHECK FAILED %0t wait ran out", $time); summarize(); end end
module eisa_system_arbiter_test import arb_pkg::*;;
    logic clk, sys_rst, dmaRotateLow, dmaRotateHigh, dramRefreshRequest;
    logic refreshDone, cpuHoldAck, nmiPending, cmdStrobeN, ioReadN;
    logic cpuHoldReq, cpuOwnsBus, refreshGrant, dmaGrant, masterTimeout;
    logic cmdTimeout, ioDataOe;
    logic [NUM_DMA-1:0] dmaReq;
    logic [NUM_MASTERS-1:0] masterReq, masterGrant;
    logic [IDX_W-1:0] dmaChannel;
    logic [15:0] ioAddr;
    logic [7:0] ioData;
    int bad_count, checks, n;
    eisa_system_arbiter eisa_system_arbiter_i (.clk(clk), .sys_rst(sys_rst),
        .dmaReq(dmaReq), .dmaRotateLow(dmaRotateLow),
        .dmaRotateHigh(dmaRotateHigh), .masterReq(masterReq),
        .dramRefreshRequest(dramRefreshRequest), .refreshDone(refreshDone),
        .cpuHoldAck(cpuHoldAck), .nmiPending(nmiPending),
        .cmdStrobeN(cmdStrobeN), .ioReadN(ioReadN), .ioAddr(ioAddr),
        .cpuHoldReq(cpuHoldReq), .cpuOwnsBus(cpuOwnsBus),
        .refreshGrant(refreshGrant), .dmaGrant(dmaGrant),
        .dmaChannel(dmaChannel), .masterGrant(masterGrant),
        .masterTimeout(masterTimeout), .cmdTimeout(cmdTimeout),
        .ioData(ioData), .ioDataOe(ioDataOe));
    host_partner host_partner_i (.clk(clk), .cpuHoldReq(cpuHoldReq),
        .refreshGrant(refreshGrant), .cpuHoldAck(cpuHoldAck),
        .refreshDone(refreshDone));
    // 20 mhz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // verdict and end of run
    task summarize();
        if (bad_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // register read through the io strobe
    task ioRead(input logic [15:0] a, input logic [7:0] e);
        ioAddr = a;
        ioReadN = 1'b0;
        `WAITC(ioDataOe === 1'b1)
        `CHK(ioData, e)
        ioReadN = 1'b1;
        `WAITC(ioDataOe === 1'b0)
    endtask
    // drop every request and wait for the cpu to park
    task releaseAll();
        masterReq = 6'h00;
        dmaReq = 8'h00;
        dramRefreshRequest = 1'b0;
        `WAITC(cpuOwnsBus === 1'b1 && cpuHoldReq === 1'b0)
    endtask
    // master granted, status ports follow ownership
    task scnMaster();
        masterReq = 6'h04;
        `WAITC(masterGrant != 6'h00)
        `CHK(masterGrant, 6'h04)
        `CHK(cpuOwnsBus, 1'b0)
        ioRead(16'h040c, 8'h01);
        releaseAll();
        ioRead(16'h0464, 8'h02);
        ioRead(16'h040c, 8'h02);
    endtask
    // fixed channel order, then the other group
    task scnDma();
        dmaReq = 8'h22;
        `WAITC(dmaGrant === 1'b1)
        `CHK(dmaChannel, 3'h1)
        `CHK(masterGrant, 6'h00)
        dmaReq = 8'h20;
        `WAITC(dmaGrant === 1'b1 && dmaChannel === 3'h5)
        `CHK(refreshGrant, 1'b0)
        releaseAll();
    endtask
    // one dma tenure on channels 0, 1, 5 and 6, then park the cpu
    task dmaRound(input logic [2:0] e);
        dmaReq = 8'h63;
        `WAITC(dmaGrant === 1'b1)
        `CHK(dmaChannel, e)
        releaseAll();
    endtask
    // both groups rotating, the served channel or slot goes last
    task scnRotate();
        dmaRotateLow = 1'b1;
        dmaRotateHigh = 1'b1;
        dmaRound(3'h0);
        dmaRound(3'h5);
        dmaRound(3'h6);
        dmaRound(3'h1);
        dmaRotateLow = 1'b0;
        dmaRotateHigh = 1'b0;
    endtask
    // refresh preempts a master through the six-bit timeout
    task scnPreempt();
        masterReq = 6'h01;
        `WAITC(masterGrant === 6'h01)
        dramRefreshRequest = 1'b1;
        `WAITC(masterTimeout === 1'b1)
        `CHK(n > 63, 1'b1)
        `CHK(masterGrant, 6'h00)
        `WAITC(refreshGrant === 1'b1)
        `CHK({masterGrant, dmaGrant}, 7'h00)
        releaseAll();
    endtask
    // nmi keeps masters and dma off the bus
    task scnNmi();
        nmiPending = 1'b1;
        masterReq = 6'h02;
        dmaReq = 8'h01;
        dramRefreshRequest = 1'b1;
        `WAITC(refreshGrant === 1'b1)
        repeat (40) begin
            @(negedge clk);
            `CHK({masterGrant, dmaGrant}, 7'h00)
        end
        `CHK(cpuOwnsBus, 1'b1)
        nmiPending = 1'b0;
        `WAITC(masterGrant != 6'h00 || dmaGrant === 1'b1)
        releaseAll();
    endtask
    // command strobe held low times out once
    task scnCmd();
        cmdStrobeN = 1'b0;
        `WAITC(cmdTimeout === 1'b1)
        `CHK(n > 254, 1'b1)
        @(negedge clk);
        `CHK(cmdTimeout, 1'b0)
        cmdStrobeN = 1'b1;
        ioAddr = 16'h040b;
        ioReadN = 1'b0;
        repeat (10) @(negedge clk);
        `CHK(ioDataOe, 1'b0)
        ioReadN = 1'b1;
    endtask
    // main sequence
    initial begin
        bad_count = 0;
        checks = 0;
        sys_rst = 1'b1;
        dmaReq = 8'h00;
        masterReq = 6'h00;
        dmaRotateLow = 1'b0;
        dmaRotateHigh = 1'b0;
        dramRefreshRequest = 1'b0;
        nmiPending = 1'b0;
        cmdStrobeN = 1'b1;
        ioReadN = 1'b1;
        ioAddr = 16'h0000;
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        `CHK({cpuOwnsBus, cpuHoldReq, ioDataOe}, 3'h4)
        `CHK({refreshGrant, dmaGrant, masterGrant}, 8'h00)
        scnMaster();
        scnDma();
        scnRotate();
        scnPreempt();
        scnNmi();
        scnCmd();
        summarize();
    end
endmodule
`default_nettype wire

// ==== test/host_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
// host cpu and refresh owner on the far side of the arbiter
module host_partner (
    input wire logic clk,
    input wire logic cpuHoldReq,
    input wire logic refreshGrant,
    output logic cpuHoldAck,
    output logic refreshDone
);
    logic [2:0] ackDly; // hold acknowledge pipeline
    logic [1:0] refCnt; // refresh cycle length
    initial begin
        ackDly = 3'h0;
        refCnt = 2'h0;
    end
    // cpu lets go a few clocks after being asked, refresh runs 4 clocks
    always @(posedge clk) begin
        ackDly <= {ackDly[1:0], cpuHoldReq};
        refCnt <= refreshGrant ? refCnt + 2'h1 : 2'h0;
    end
    assign cpuHoldAck = ackDly[2];
    // refresh owner hands the bus back
    assign refreshDone = refreshGrant && (refCnt == 2'h3);
endmodule
`default_nettype wire
